// *** lut_cell_pkg.sv ***
// Behaviour
// - six-input function: same five signals on both ports, carry port adds sixth, result f1
// - mux combine: f1 is upper half result when sixth input high, else lower
// - every quarter table owns a carry net into the next quarter table; the top one feeds carry_out and o4 instead
// - ripple mode: operands on a[3:0] and b[3:0], one result per quarter on f[3:0]
// - lowest ripple input from ripple-in: fast route, b4, one or zero
// - top carry goes to carry_out, to o4, or to both
// - direction or operation control on a4 steers every ripple stage
// - each quarter makes result bit plus propagate choice between pass and generate
// - memory mode: each half table is a 16 word by 2 bit memory
// - as 16x4 memory a4 and b4 are write strobes, direct data is write data
// - memory read data may go to unit outputs or storage element inputs
// - one half may be memory while the other is a five-input function
// - each element: positive or negative latch, rising or falling flip-flop
// - one common clock with polarity, one common data source selection
// - with no table, direct or pad source the element data input is zero
// - storage outputs can be placed on the five unit outputs
// - clock enable only on flip-flops, as a new-or-held data multiplexer
// - inactive clock enable holds value unless asynchronous set or reset
// - clock enable and local set/reset polarities are configurable
// - synchronous local set/reset acts at a flip-flop edge with clock enable active, or while a latch is open
// - active-low global set/reset is asynchronous; per-element bit picks set or clear
// - unused local set/reset may select table output or direct data
// - outer-ring elements also take pad fast paths; both only in corner cells
// - clock enable may be turned off so every active clock counts
// - local set/reset is off by default and covers all four elements
package lut_cell_pkg;

	localparam int QT_BITS    = 16;
	localparam int TABLE_BITS = 64;
	localparam int NUM_ELEM   = 4;
	localparam int NUM_OUT    = 5;

	localparam logic [TABLE_BITS-1:0] TABLE_RESET = 64'h0;
	localparam logic                  STATE_RESET = 1'h0;

	// quarter table numbers, upper half holds 2 and 3
	localparam logic [1:0] QT_B0 = 2'h0;
	localparam logic [1:0] QT_B1 = 2'h1;
	localparam logic [1:0] QT_A2 = 2'h2;
	localparam logic [1:0] QT_A3 = 2'h3;

	// ripple quarter layout: low 8 bits sum, then propagate, then generate
	localparam logic [1:0] RIP_PROP = 2'h2;
	localparam logic [1:0] RIP_GEN  = 2'h3;

	typedef enum logic [1:0] {
		HALF_FUNC5  = 2'b00,
		HALF_FUNC4  = 2'b01,
		HALF_MEMORY = 2'b10
	} half_mode_t;

	typedef enum logic [1:0] {
		COMBINE_NONE = 2'b00,
		COMBINE_MUX  = 2'b01,
		COMBINE_XOR  = 2'b10
	} combine_t;

	typedef enum logic [1:0] {
		RIN_FAST = 2'b00,
		RIN_B4   = 2'b01,
		RIN_ONE  = 2'b10,
		RIN_ZERO = 2'b11
	} ripple_in_t;

	typedef enum logic [1:0] {
		LSR_OFF    = 2'b00,
		LSR_SYNC   = 2'b01,
		LSR_ASYNC  = 2'b10,
		LSR_SELECT = 2'b11
	} lsr_mode_t;

	typedef enum logic [2:0] {
		SRC_ZERO     = 3'b000,
		SRC_TABLE    = 3'b001,
		SRC_DIRECT   = 3'b010,
		SRC_PAD_SIDE = 3'b011,
		SRC_PAD_TB   = 3'b100
	} data_src_t;

	typedef enum logic [1:0] {
		O4_ZERO  = 2'b00,
		O4_CARRY = 2'b01,
		O4_STORE = 2'b10
	} out4_t;

	typedef struct packed {
		half_mode_t           upper_mode;
		half_mode_t           lower_mode;
		combine_t             combine;
		logic                 ripple_en;
		logic                 updown_en;
		ripple_in_t           ripple_in;
		logic                 carry_out_en;
		out4_t                o4_src;
		logic [1:0]           o4_store_idx;
		logic [NUM_ELEM-1:0]  out_from_store;
		data_src_t            data_src;
		lsr_mode_t            lsr_mode;
		logic                 ck_invert;
		logic                 ce_used;
		logic                 ce_invert;
		logic                 lsr_invert;
		logic [NUM_ELEM-1:0]  elem_latch;
		logic [NUM_ELEM-1:0]  elem_neg;
		logic [NUM_ELEM-1:0]  elem_set;
	} cfg_t;

	typedef struct packed {
		logic [4:0]          a;
		logic [4:0]          b;
		logic [NUM_ELEM-1:0] direct_data_in;
		logic                carry_or_sixth_input;
	} data_in_t;

	typedef struct packed {
		logic ck;
		logic ce;
		logic lsr;
		logic gsr_n;
	} control_t;

endpackage

// *** storage_element.sv ***
`timescale 1ns/10ps
module storage_element (
	input  wire logic clock,
	input  wire logic rst,
	input  wire logic ck_level,
	input  wire logic is_latch,
	input  wire logic ce_active,
	input  wire logic sync_sr,
	input  wire logic async_sr,
	input  wire logic set_value,
	input  wire logic d,
	output logic      q
);
	import lut_cell_pkg::*;

	logic ck_prev;
	logic state;
	logic next_state;

	// ----------------------------------------
	// cell clock tracking
	// ----------------------------------------
	always_ff @(posedge clock) begin
		if (rst) begin
			ck_prev <= STATE_RESET;
		end else begin
			ck_prev <= ck_level;
		end
	end

	// ----------------------------------------
	// storage
	// ----------------------------------------
	always_comb begin
		next_state = state;
		if (is_latch) begin
			if (ck_level) begin
				next_state = sync_sr ? set_value : d;
			end
		end else if (ck_level && !ck_prev && ce_active) begin
			next_state = sync_sr ? set_value : d;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			state <= STATE_RESET;
		end else if (async_sr) begin
			state <= set_value;
		end else begin
			state <= next_state;
		end
	end

	// asynchronous set/reset shows at once, not after the next edge
	assign q = async_sr ? set_value : state;
endmodule

// *** function_unit.sv ***
`timescale 1ns/10ps
module function_unit #(
	parameter bit IN_SIDE_RING = 1'b0,
	parameter bit IN_TB_RING   = 1'b0
) (
	input  wire logic                            clock,
	input  wire logic                            rst,
	input  wire lut_cell_pkg::cfg_t              cfg,
	input  wire logic                            table_load,
	input  wire logic [lut_cell_pkg::TABLE_BITS-1:0] table_init,
	input  wire lut_cell_pkg::data_in_t          din,
	input  wire lut_cell_pkg::control_t          ctl,
	input  wire logic [lut_cell_pkg::NUM_ELEM-1:0] pad_side,
	input  wire logic [lut_cell_pkg::NUM_ELEM-1:0] pad_tb,
	input  wire logic                            carry_in_fast,
	output logic      [lut_cell_pkg::NUM_OUT-1:0]  o,
	output logic                                 carry_out
);
	import lut_cell_pkg::*;

	logic [TABLE_BITS-1:0] table_bits;
	logic [NUM_ELEM-1:0]   f;
	logic [NUM_ELEM-1:0]   q;
	logic [NUM_ELEM-1:0]   ripple_sum;
	logic [NUM_ELEM:0]     carry;
	logic [NUM_ELEM-1:0]   upper_f;
	logic [NUM_ELEM-1:0]   lower_f;
	logic                  ck_eff;
	logic                  ck_prev;
	logic                  ck_edge;
	logic                  we_upper;
	logic                  we_lower;
	logic                  lsr_act;
	logic                  ce_act;
	logic                  sync_sr;
	logic                  async_sr;
	logic                  dir_ctl;
	logic                  half_a5;
	logic                  half_b5;
	logic                  carry_seed;
	logic                  out4;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic pick_data(
		input data_src_t src,
		input logic      from_table,
		input logic      from_direct,
		input logic      from_side,
		input logic      from_tb
	);
		logic r;
		r = 1'b0;
		unique case (src)
			SRC_TABLE:    r = from_table;
			SRC_DIRECT:   r = from_direct;
			SRC_PAD_SIDE: r = IN_SIDE_RING ? from_side : 1'b0;
			SRC_PAD_TB:   r = IN_TB_RING ? from_tb : 1'b0;
			SRC_ZERO:     r = 1'b0;
			default:      r = 1'b0;
		endcase
		return r;
	endfunction

	// ----------------------------------------
	// cell clock and control polarity
	// ----------------------------------------
	assign ck_eff  = ctl.ck ^ cfg.ck_invert;
	assign ck_edge = ck_eff & ~ck_prev;

	always_ff @(posedge clock) begin
		if (rst) begin
			ck_prev <= STATE_RESET;
		end else begin
			ck_prev <= ck_eff;
		end
	end

	assign lsr_act = ctl.lsr ^ cfg.lsr_invert;
	// disabled clock enable means every active edge counts
	assign ce_act  = cfg.ce_used ? (ctl.ce ^ cfg.ce_invert) : 1'b1;
	assign sync_sr = (cfg.lsr_mode == LSR_SYNC) & lsr_act;
	assign async_sr = ~ctl.gsr_n | ((cfg.lsr_mode == LSR_ASYNC) & lsr_act);

	// ----------------------------------------
	// table storage and memory writes
	// ----------------------------------------
	assign we_upper = !cfg.ripple_en && cfg.upper_mode == HALF_MEMORY && din.a[4];
	assign we_lower = !cfg.ripple_en && cfg.lower_mode == HALF_MEMORY && din.b[4];

	// writes follow the cell clock edge so memory behaves like a synchronous ram
	always_ff @(posedge clock) begin
		if (rst) begin
			table_bits <= TABLE_RESET;
		end else if (table_load) begin
			table_bits <= table_init;
		end else if (ck_edge) begin
			if (we_upper) begin
				table_bits[{QT_A2, din.a[3:0]}] <= din.direct_data_in[2];
				table_bits[{QT_A3, din.a[3:0]}] <= din.direct_data_in[3];
			end
			if (we_lower) begin
				table_bits[{QT_B0, din.b[3:0]}] <= din.direct_data_in[0];
				table_bits[{QT_B1, din.b[3:0]}] <= din.direct_data_in[1];
			end
		end
	end

	// ----------------------------------------
	// ripple chain
	// ----------------------------------------
	assign dir_ctl = cfg.updown_en & din.a[4];

	always_comb begin
		unique case (cfg.ripple_in)
			RIN_FAST: carry_seed = carry_in_fast;
			RIN_B4:   carry_seed = din.b[4];
			RIN_ONE:  carry_seed = 1'b1;
			RIN_ZERO: carry_seed = 1'b0;
		endcase
	end

	// seed kept apart so the chain vector has one kind of driver
	assign carry[0] = carry_seed;

	genvar gi;
	generate
		for (gi = 0; gi < NUM_ELEM; gi++) begin : g_ripple
			logic [QT_BITS-1:0] qbits;
			logic               op_b;
			logic               prop;
			logic               gen;

			assign qbits = table_bits[gi*QT_BITS +: QT_BITS];
			// a4 flips the second operand in every stage
			assign op_b = din.b[gi] ^ dir_ctl;
			assign ripple_sum[gi] = qbits[{1'b0, carry[gi], din.a[gi], op_b}];
			assign prop = qbits[{RIP_PROP, din.a[gi], op_b}];
			assign gen  = qbits[{RIP_GEN, din.a[gi], op_b}];
			assign carry[gi+1] = prop ? carry[gi] : gen;
		end
	endgenerate

	// ----------------------------------------
	// half table reads
	// ----------------------------------------
	assign half_a5 = table_bits[{1'b1, din.a[4:0]}];
	assign half_b5 = table_bits[{1'b0, din.b[4:0]}];

	// upper half drives f3 and f2
	always_comb begin
		upper_f = '0;
		unique case (cfg.upper_mode)
			HALF_FUNC5: begin
				upper_f[3] = half_a5;
			end
			HALF_FUNC4: begin
				upper_f[3] = table_bits[{QT_A3, din.a[3:1], din.a[4]}];
				upper_f[2] = table_bits[{QT_A2, din.a[3:0]}];
			end
			HALF_MEMORY: begin
				upper_f[3] = table_bits[{QT_A3, din.a[3:0]}];
				upper_f[2] = table_bits[{QT_A2, din.a[3:0]}];
			end
			default: begin
				upper_f = '0;
			end
		endcase
	end

	// lower half drives f1 and f0
	always_comb begin
		lower_f = '0;
		unique case (cfg.lower_mode)
			HALF_FUNC5: begin
				lower_f[0] = half_b5;
			end
			HALF_FUNC4: begin
				lower_f[1] = table_bits[{QT_B1, din.b[3:1], din.b[4]}];
				lower_f[0] = table_bits[{QT_B0, din.b[3:0]}];
			end
			HALF_MEMORY: begin
				lower_f[1] = table_bits[{QT_B1, din.b[3:0]}];
				lower_f[0] = table_bits[{QT_B0, din.b[3:0]}];
			end
			default: begin
				lower_f = '0;
			end
		endcase
	end

	// ----------------------------------------
	// table outputs and combine gates
	// ----------------------------------------
	always_comb begin
		f = upper_f | lower_f;
		if (cfg.ripple_en) begin
			// ripple mode takes the whole table
			f = ripple_sum;
		end else if (cfg.upper_mode == HALF_FUNC5 && cfg.lower_mode == HALF_FUNC5) begin
			unique case (cfg.combine)
				COMBINE_MUX: begin
					// six inputs when both ports carry the same five signals
					f[1] = din.carry_or_sixth_input ? f[3] : f[0];
					f[2] = ~(f[3] & f[0] & din.carry_or_sixth_input);
				end
				COMBINE_XOR: begin
					f[1] = f[3] ^ f[0] ^ din.carry_or_sixth_input;
					f[2] = ~(f[3] & f[0] & din.carry_or_sixth_input);
				end
				COMBINE_NONE: begin
					f[1] = 1'b0;
				end
				default: begin
					f[1] = 1'b0;
				end
			endcase
		end
	end

	// ----------------------------------------
	// storage elements
	// ----------------------------------------
	generate
		for (gi = 0; gi < NUM_ELEM; gi++) begin : g_store
			logic d;

			always_comb begin
				if (cfg.lsr_mode == LSR_SELECT) begin
					// select mode reuses lsr as the front-end data choice
					d = lsr_act ? din.direct_data_in[gi] : f[gi];
				end else begin
					d = pick_data(cfg.data_src, f[gi], din.direct_data_in[gi],
						pad_side[gi], pad_tb[gi]);
				end
			end

			storage_element u_elem (
				.clock     (clock),
				.rst       (rst),
				.ck_level  (ck_eff ^ cfg.elem_neg[gi]),
				.is_latch  (cfg.elem_latch[gi]),
				.ce_active (ce_act),
				.sync_sr   (sync_sr),
				.async_sr  (async_sr),
				.set_value (cfg.elem_set[gi]),
				.d         (d),
				.q         (q[gi])
			);
		end
	endgenerate

	// ----------------------------------------
	// unit outputs
	// ----------------------------------------
	generate
		for (gi = 0; gi < NUM_ELEM; gi++) begin : g_out
			// table outputs bypass the storage for the shortest path
			assign o[gi] = cfg.out_from_store[gi] ? q[gi] : f[gi];
		end
	endgenerate

	always_comb begin
		unique case (cfg.o4_src)
			O4_CARRY: out4 = cfg.ripple_en & carry[NUM_ELEM];
			O4_STORE: out4 = q[cfg.o4_store_idx];
			O4_ZERO:  out4 = 1'b0;
			default:  out4 = 1'b0;
		endcase
	end

	assign o[4] = out4;

	assign carry_out = cfg.ripple_en & cfg.carry_out_en & carry[NUM_ELEM];

endmodule

// *** fabric_model.sv ***
`timescale 1ns/10ps
module fabric_model (
	input  wire logic       clock,
	input  wire logic       rd_en,
	input  wire logic [3:0] cell_out,
	output logic      [3:0] read_bus
);
	logic [3:0] last;

	always_ff @(posedge clock) begin
		if (rd_en) begin
			last <= cell_out;
		end
	end

	// released bus shows the inverse of the last word, never a stale copy
	assign read_bus = rd_en ? cell_out : ~last;
endmodule

// *** function_unit_asserts.sv ***
`timescale 1ns/10ps
module function_unit_asserts (
	input wire logic                             clock,
	input wire logic                             rst,
	input wire lut_cell_pkg::cfg_t               cfg,
	input wire logic                             table_load,
	input wire lut_cell_pkg::data_in_t           din,
	input wire lut_cell_pkg::control_t           ctl,
	input wire logic [lut_cell_pkg::NUM_OUT-1:0] o,
	input wire logic                             carry_out
);
	import lut_cell_pkg::*;
	// ------------------
	// derived terms
	// ------------------
	wire logic comb  = cfg.upper_mode == HALF_FUNC5 && cfg.lower_mode == HALF_FUNC5
		&& !cfg.ripple_en && cfg.out_from_store == 4'h0;
	wire logic sixth = din.carry_or_sixth_input;
	wire logic ck_ef = ctl.ck ^ cfg.ck_invert;
	wire logic lv0   = ck_ef ^ cfg.elem_neg[0];
	wire logic st0   = cfg.out_from_store[0] && !cfg.elem_latch[0] && ctl.gsr_n;
	wire logic ce_on = !cfg.ce_used || ctl.ce != cfg.ce_invert;

	default clocking dc @(posedge clock); endclocking
	default disable iff (rst);

	mux_combine_a: assert property (comb && cfg.combine == COMBINE_MUX
		|-> o[1] == (sixth ? o[3] : o[0])) else $error("mux combine output wrong");
	carry_gate_a: assert property (!(cfg.ripple_en && cfg.carry_out_en)
		|-> !carry_out) else $error("carry out driven while disabled");
	o4_carry_a: assert property (cfg.ripple_en && cfg.carry_out_en
		&& cfg.o4_src == O4_CARRY |-> o[4] == carry_out) else $error("o4 differs from carry");
	flop_hold_a: assert property (st0 && cfg.ce_used && ctl.ce == cfg.ce_invert
		&& cfg.lsr_mode != LSR_ASYNC ##1 ctl.gsr_n && $stable(cfg) |-> $stable(o[0]))
		else $error("flop changed with enable inactive");
	flop_capture_a: assert property (st0 && ce_on && lv0 && !$past(lv0) && !$past(rst)
		&& cfg.data_src == SRC_DIRECT && cfg.lsr_mode == LSR_OFF ##1 ctl.gsr_n && $stable(cfg)
		|-> o[0] == $past(din.direct_data_in[0])) else $error("flop did not capture");
	global_sr_a: assert property (!ctl.gsr_n && cfg.out_from_store[0]
		|-> o[0] == cfg.elem_set[0]) else $error("global set/reset value wrong");
	local_async_a: assert property (cfg.lsr_mode == LSR_ASYNC && ctl.lsr != cfg.lsr_invert
		&& cfg.out_from_store[0] |-> o[0] == cfg.elem_set[0]) else $error("async lsr ignored");
	mem_write_a: assert property (cfg.upper_mode == HALF_MEMORY && !cfg.ripple_en
		&& ck_ef && !$past(ck_ef) && !$past(rst) && din.a[4] && !table_load
		##1 $stable(din.a[3:0]) && $stable(cfg) && !cfg.out_from_store[2]
		|-> o[2] == $past(din.direct_data_in[2])) else $error("memory word not written");
endmodule

bind function_unit function_unit_asserts i_function_unit_asserts (
	.clock(clock), .rst(rst), .cfg(cfg), .table_load(table_load),
	.din(din), .ctl(ctl), .o(o), .carry_out(carry_out)
);

// *** tb_top.sv ***
`timescale 1ns/10ps
module tb_top;
	import lut_cell_pkg::*;
	logic                  clock;
	logic                  rst;
	cfg_t                  cfg;
	logic                  table_load;
	logic [TABLE_BITS-1:0] table_init;
	data_in_t              din;
	control_t              ctl;
	logic [NUM_ELEM-1:0]   pad_side;
	logic [NUM_ELEM-1:0]   pad_tb;
	logic                  carry_in_fast;
	logic [NUM_OUT-1:0]    o;
	logic                  carry_out;
	logic                  rd_en;
	logic [3:0]            bus;
	logic [63:0]           tbl;
	int                    failures = 0;
	int                    samples_checked = 0;
	int                    cycles = 0;

	function_unit i_dut (
		.clock        (clock),
		.rst          (rst),
		.cfg          (cfg),
		.table_load   (table_load),
		.table_init   (table_init),
		.din          (din),
		.ctl          (ctl),
		.pad_side     (pad_side),
		.pad_tb       (pad_tb),
		.carry_in_fast(carry_in_fast),
		.o            (o),
		.carry_out    (carry_out)
	);
	fabric_model i_fabric (
		.clock   (clock),
		.rd_en   (rd_en),
		.cell_out(o[3:0]),
		.read_bus(bus)
	);

	// ------------------
	// helpers
	// ------------------
	always #2 clock = ~clock;

	task automatic final_report();
		$display("checks %0d failures %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// well above the few hundred cycles the sequence needs
	always @(posedge clock) begin
		cycles++;
		if (cycles == 3000) begin
			failures++;
			final_report();
		end
	end

	task automatic chk(input string name, input logic [4:0] exp, input logic [4:0] got);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic step(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask

	// cell clock is plain data: two samples per level so an edge is seen
	task automatic ck_to(input logic v);
		ctl.ck = v;
		step(2);
	endtask

	task automatic pulse();
		ck_to(1'b1);
		ck_to(1'b0);
	endtask

	task automatic load(input logic [63:0] t);
		table_init = t;
		table_load = 1'b1;
		step(1);
		table_load = 1'b0;
	endtask

	// ------------------
	// sequence
	// ------------------
	initial begin
		logic       f0;
		logic       f3;
		logic       mx;
		logic       cin;
		logic [3:0] bv;
		logic [4:0] sum;
		clock = 1'b0;
		cfg = '0;
		din = '0;
		ctl = '0;
		ctl.gsr_n = 1'b1;
		table_load = 1'b0;
		table_init = '0;
		pad_side = 4'hF;
		pad_tb = 4'hF;
		carry_in_fast = 1'b0;
		rd_en = 1'b0;
		rst = 1'b1;
		step(20);
		rst = 1'b0;
		tbl = 64'h6A5C_33F0_0FF0_9C3A;
		load(tbl);
		for (int m = 0; m < 2; m++) begin
			cfg.combine = m ? COMBINE_XOR : COMBINE_MUX;
			for (int k = 0; k < 64; k++) begin
				din.a = k[4:0];
				din.b = k[4:0];
				din.carry_or_sixth_input = k[5];
				step(1);
				f0 = tbl[{1'b0, k[4:0]}];
				f3 = tbl[{1'b1, k[4:0]}];
				mx = m ? (f3 ^ f0 ^ k[5]) : (k[5] ? f3 : f0);
				chk("combine", {1'b0, f3, ~(f3 & f0 & k[5]), mx, f0}, o);
			end
		end
		// quarter: sum 96, propagate 6, generate 8
		load(64'h8696_8696_8696_8696);
		cfg.combine = COMBINE_NONE;
		cfg.ripple_en = 1'b1;
		cfg.carry_out_en = 1'b1;
		cfg.o4_src = O4_CARRY;
		for (int u = 0; u < 2; u++) begin
			for (int r = 0; r < 4; r++) begin
				for (int i = 0; i < 16; i++) begin
					cfg.updown_en = u[0];
					cfg.ripple_in = ripple_in_t'(r[1:0]);
					bv = 4'((i * 7) & 15);
					din.a = {i[2], i[3:0]};
					din.b = {i[0], bv};
					carry_in_fast = i[1];
					step(1);
					cin = (r == 0) ? i[1] : (r == 1) ? i[0] : (r == 2);
					sum = 5'(i[3:0]) + 5'(bv ^ {4{u[0] && i[2]}}) + 5'(cin);
					chk("ripple", sum, o);
					chk("carry", {4'h0, sum[4]}, {4'h0, carry_out});
				end
			end
		end
		cfg.carry_out_en = 1'b0;
		step(1);
		chk("carry_off", 5'h00, {4'h0, carry_out});
		cfg = '0;
		cfg.upper_mode = HALF_MEMORY;
		cfg.lower_mode = HALF_MEMORY;
		for (int i = 0; i < 16; i++) begin
			din.a = {1'b1, i[3:0]};
			din.b = {1'b1, i[3:0]};
			din.direct_data_in = i[3:0] ^ 4'h5;
			pulse();
		end
		// strobes stay high with no cell clock edge: nothing may be written
		din.direct_data_in = 4'hF;
		rd_en = 1'b1;
		for (int i = 0; i < 16; i++) begin
			din.a[3:0] = i[3:0];
			din.b[3:0] = i[3:0];
			step(1);
			chk("mem_read", {1'b0, i[3:0] ^ 4'h5}, o);
			chk("read_bus", {1'b0, i[3:0] ^ 4'h5}, {1'b0, bus});
		end
		rd_en = 1'b0;
		cfg.lower_mode = HALF_FUNC5;
		din.a = 5'h10;
		din.b = 5'h10;
		pulse();
		chk("split", 5'h0C, o & 5'h0D);
		cfg = '0;
		cfg.out_from_store = 4'hF;
		cfg.elem_set = 4'hA;
		ctl.gsr_n = 1'b0;
		step(1);
		chk("global_sr", 5'h0A, o);
		ctl.gsr_n = 1'b1;
		din.direct_data_in = 4'h5;
		pulse();
		chk("zero_src", 5'h00, o);
		cfg.data_src = SRC_DIRECT;
		pulse();
		chk("direct", 5'h05, o);
		cfg.data_src = SRC_PAD_TB;
		pulse();
		chk("pad_tb_off", 5'h00, o);
		cfg.data_src = SRC_DIRECT;
		pulse();
		chk("direct_again", 5'h05, o);
		cfg.data_src = SRC_PAD_SIDE;
		pulse();
		chk("pad_off", 5'h00, o);
		cfg.data_src = SRC_DIRECT;
		cfg.ce_used = 1'b1;
		din.direct_data_in = 4'hA;
		pulse();
		chk("ce_hold", 5'h00, o);
		cfg.ce_invert = 1'b1;
		pulse();
		chk("ce_low", 5'h0A, o);
		ctl.ce = 1'b1;
		cfg.elem_set = 4'h6;
		cfg.lsr_mode = LSR_SYNC;
		ctl.lsr = 1'b1;
		pulse();
		chk("sync_gated", 5'h0A, o);
		ctl.ce = 1'b0;
		pulse();
		chk("sync_lsr", 5'h06, o);
		cfg.lsr_mode = LSR_OFF;
		din.direct_data_in = 4'h9;
		pulse();
		chk("lsr_off", 5'h09, o);
		cfg.lsr_mode = LSR_ASYNC;
		step(1);
		chk("async_lsr", 5'h06, o);
		cfg.lsr_mode = LSR_SELECT;
		din.direct_data_in = 4'hC;
		pulse();
		chk("select", 5'h0C, o);
		// select low takes the table: upper quarter bit set, lower clear
		ctl.lsr = 1'b0;
		pulse();
		chk("select_table", 5'h08, o);
		cfg.lsr_mode = LSR_OFF;
		cfg.ce_used = 1'b0;
		cfg.elem_neg = 4'h3;
		din.direct_data_in = 4'h3;
		ck_to(1'b1);
		chk("rise_only", 5'h00, o);
		ck_to(1'b0);
		chk("fall_too", 5'h03, o);
		cfg.elem_neg = 4'h0;
		cfg.elem_latch = 4'hF;
		din.direct_data_in = 4'h9;
		ck_to(1'b1);
		chk("latch_open", 5'h09, o);
		ck_to(1'b0);
		din.direct_data_in = 4'h6;
		step(2);
		chk("latch_shut", 5'h09, o);
		cfg.elem_latch = 4'h0;
		cfg.ck_invert = 1'b1;
		step(2);
		din.direct_data_in = 4'h5;
		ck_to(1'b1);
		chk("inv_hold", 5'h06, o);
		ck_to(1'b0);
		chk("inv_take", 5'h05, o);
		cfg.o4_src = O4_STORE;
		cfg.o4_store_idx = 2'h2;
		step(1);
		chk("o4_store_hi", 5'h15, o);
		cfg.o4_store_idx = 2'h1;
		step(1);
		chk("o4_store_lo", 5'h05, o);
		// four-input halves read the memory contents left behind above
		cfg.out_from_store = 4'h0;
		cfg.o4_src = O4_ZERO;
		cfg.upper_mode = HALF_FUNC4;
		cfg.lower_mode = HALF_FUNC4;
		din.a = 5'h10;
		din.b = 5'h12;
		step(1);
		chk("func4", 5'h07, o);
		final_report();
	end
endmodule
